// ==== shared/ssc_defs.svh ====
// constants for the stepper stop, status, index and input-read command block
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH
`define SSC_CH_PIPE      8'h7C
`define SSC_CH_CARET     8'h5E
`define SSC_CH_BRACE     8'h7B
`define SSC_CH_PLUS      8'h2B
`define SSC_CH_MINUS     8'h2D
`define SSC_CH_A_UP      8'h41
`define SSC_CH_A_LO      8'h61
`define SSC_CH_CR        8'h0D
`define SSC_CH_LF        8'h0A
`define SSC_CH_ZERO      8'h30
`define SSC_CH_ONE       8'h31
`define SSC_CH_NAK       8'h3F
`define SSC_POS_MAX      32'h7FFFFFFF
// register byte offsets
`define SSC_REG_CTRL     8'h00
`define SSC_REG_PROF     8'h04
`define SSC_REG_START    8'h08
`define SSC_REG_SLEW     8'h0C
`define SSC_REG_HOLD     8'h10
`define SSC_REG_STATUS   8'h14
`define SSC_REG_POS      8'h18
`define SSC_REG_TEMP     8'h1C
// control field positions
`define SSC_CTRL_MULTI   0
`define SSC_CTRL_PROG    1
`define SSC_CTRL_PENTRY  2
`define SSC_CTRL_RUNPRG  3
// reset values
`define SSC_RST_NAME     8'h41
`define SSC_RST_START    16'h0064
`define SSC_RST_SLEW     16'h03E8
`define SSC_RST_ACCEL    16'h0010
`define SSC_RST_HOLD     8'h64
// timing: hold delay tick is 10 ms at 40 MHz
`define SSC_TICK_MS      10
`define SSC_CLK_KHZ      40000
`define SSC_TICK_CYC     (`SSC_TICK_MS * `SSC_CLK_KHZ)
`endif

// ==== shared/ssc_pkg.sv ====
// types of the stepper command block
package ssc_pkg;
  typedef enum logic [2:0] {
    SSC_IDLE  = 3'b000,
    SSC_ADDR  = 3'b001,
    SSC_NUM   = 3'b010,
    SSC_LINE  = 3'b011,
    SSC_WAIT  = 3'b100
  } ssc_state_t;
  typedef enum logic [1:0] {
    SSC_OP_NONE = 2'b00,
    SSC_OP_PLUS = 2'b01,
    SSC_OP_MIN  = 2'b10,
    SSC_OP_INP  = 2'b11
  } ssc_op_t;
endpackage : ssc_pkg

// ==== shared/ssc_move_if.sv ====
// command path between parser and motion generator
`timescale 1ns/1ps
interface ssc_move_if;
  logic        start;
  logic        dir_neg;
  logic [30:0] count;
  logic        kill;
  logic        moving;
  logic        step;
  logic        run_cur;
  modport ctl (output start, output dir_neg, output count, output kill,
               input moving, input step, input run_cur);
  modport gen (input start, input dir_neg, input count, input kill,
               output moving, output step, output run_cur);
endinterface : ssc_move_if

// ==== src/ssc_motion.sv ====
// trapezoid step generator with hold-current settling timer
`timescale 1ns/1ps
`include "ssc_defs.svh"
module ssc_motion (
  input  wire logic        sys_clk_in,
  input  wire logic        resetn_in,
  ssc_move_if.gen          mv,
  input  wire logic [15:0] start_rate_in,
  input  wire logic [15:0] slew_rate_in,
  input  wire logic [15:0] accel_in,
  input  wire logic [7:0]  hold_ticks_in
);
  logic [30:0] left, next_left;
  logic [30:0] done_cnt, next_done_cnt;
  logic [15:0] rate, next_rate;
  logic [31:0] phase, next_phase;
  logic        moving, next_moving;
  logic        step, next_step;
  logic        run_cur, next_run_cur;
  logic [31:0] tick, next_tick;
  logic [7:0]  hold, next_hold;

  //////////////////////////////////////////////////////////////////////
  // rate accumulator: one step each time phase passes 40 M
  always_comb begin
    next_left     = left;
    next_done_cnt = done_cnt;
    next_rate     = rate;
    next_phase    = phase;
    next_moving   = moving;
    next_step     = 1'b0;
    next_run_cur  = run_cur;
    next_tick     = tick;
    next_hold     = hold;
    if (mv.kill) begin
      next_moving = 1'b0;                              // no ramp down [RQ3]
      next_left   = 31'h00000000;
    end else if (mv.start && !moving) begin
      next_run_cur  = 1'b1;                            // run current [RQ16]
      next_rate     = start_rate_in;                   // begin at start speed [RQ16]
      if (start_rate_in >= slew_rate_in) begin
        next_rate = slew_rate_in;                      // no accel phase [RQ17]
      end
      next_left     = mv.count;
      next_done_cnt = 31'h00000000;
      next_phase    = 32'h00000000;
      next_moving   = (mv.count != 31'h00000000);
      next_hold     = 8'h00;
      next_tick     = 32'h00000000;
    end else if (moving) begin
      next_phase = phase + {16'h0000, rate};
      if (phase >= 32'(`SSC_CLK_KHZ * 1000)) begin
        next_phase    = 32'h00000000;
        next_step     = 1'b1;
        next_left     = left - 31'h00000001;
        next_done_cnt = done_cnt + 31'h00000001;
        next_moving   = (left != 31'h00000001);
        next_hold     = 8'h00;                         // each step restarts wait [RQ19]
        next_tick     = 32'h00000000;
        // ramp down once remaining steps fall to the number of steps already taken [RQ18]
        if (left <= done_cnt && rate > start_rate_in && start_rate_in < slew_rate_in) begin
          next_rate = (rate - accel_in < start_rate_in) ? start_rate_in : rate - accel_in;
        end else if (rate < slew_rate_in) begin
          next_rate = (slew_rate_in - rate < accel_in) ? slew_rate_in : rate + accel_in;
        end
      end
    end else if (run_cur) begin
      next_tick = tick + 32'h00000001;
      if (tick == 32'(`SSC_TICK_CYC - 1)) begin
        next_tick = 32'h00000000;
        next_hold = hold + 8'h01;
        if (hold + 8'h01 >= hold_ticks_in) begin
          next_run_cur = 1'b0;                         // switch to hold current [RQ19]
        end
      end
    end
  end

  // state registers
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      left     <= 31'h00000000;
      done_cnt <= 31'h00000000;
      rate     <= 16'h0000;
      phase    <= 32'h00000000;
      moving   <= 1'b0;
      step     <= 1'b0;
      run_cur  <= 1'b0;
      tick     <= 32'h00000000;
      hold     <= 8'h00;
    end else begin
      left     <= next_left;
      done_cnt <= next_done_cnt;
      rate     <= next_rate;
      phase    <= next_phase;
      moving   <= next_moving;
      step     <= next_step;
      run_cur  <= next_run_cur;
      tick     <= next_tick;
      hold     <= next_hold;
    end
  end

  assign mv.moving  = moving;
  assign mv.step    = step;
  assign mv.run_cur = run_cur;
endmodule : ssc_motion

// ==== src/ssc_cmd.sv ====
// serial command interpreter: hard stop, status, temperature, index, input read
// How it works
// RQ1: pipe character 7C is a complete hard stop, no terminator needed.
// RQ2: hard stop acts only on the addressed or directly connected unit.
// RQ3: hard stop ends stepping at once without deceleration.
// RQ4: hard stop halts program, leaves program mode, idles in immediate mode.
// RQ5: hard stop in multi-axis mode keeps multi-axis mode.
// RQ6: hard stop leaves output configuration and levels alone.
// RQ7: hard stop sends no echo.
// RQ8: hard stop during program entry stores nothing and leaves entry mode.
// RQ9: hard stop accepted anytime alone; soft stop needs its own CR LF line. No soft stop command is decoded here.
// RQ10: status query answers 1 while stepping, 0 otherwise.
// RQ11: status query is rejected in program mode.
// RQ12: status reply is immediate and ignores the hold settling timer.
// RQ13: temperature query returns degrees Celsius near the driver.
// RQ14: plus index takes 0 to 2147483647 steps, relative move positive.
// RQ15: position counter wraps from max positive to most negative.
// RQ16: index waits for earlier motion, then run current and start speed.
// RQ17: start speed at or above slew skips acceleration.
// RQ18: otherwise accelerate, slew, decelerate, stop on target.
// RQ19: hold current after settling delay without steps; steps restart it.
// RQ20: program motion commands wait for earlier motion.
// RQ21: minus index mirrors plus index, magnitudes only.
// RQ22: input read packs inputs 1..4 into weights 1..8, low pin is 1.
// RQ23: host uses only a letter as the axis name prefix.
`timescale 1ns/1ps
`include "ssc_defs.svh"
module ssc_cmd (
  input  wire logic        sys_clk_in,
  input  wire logic        resetn_in,
  input  wire logic        rx_valid_in,
  input  wire logic [7:0]  rx_data_in,
  output logic             tx_valid_out,
  output logic [7:0]       tx_data_out,
  input  wire logic        tx_ready_in,
  input  wire logic [3:0]  input_n_in,
  input  wire logic [7:0]  temp_c_in,
  output logic             step_out,
  output logic             dir_out,
  output logic             run_current_out,
  output logic [31:0]      position_out,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp
);
  ssc_move_if mv ();

  logic [3:0]  in_s1, in_s2;
  logic [7:0]  t_s1, t_s2;
  ssc_pkg::ssc_state_t st, next_st;
  ssc_pkg::ssc_op_t    op, next_op;
  logic [31:0] num, next_num;
  logic        pend, next_pend;
  logic [7:0]  tx, next_tx;
  logic        txv, next_txv;
  logic [3:0]  ctrl, next_ctrl;
  logic [7:0]  name, next_name;
  logic [31:0] pos, next_pos;
  logic        dir, next_dir;
  logic        start, kill;
  logic [15:0] r_start, r_slew, r_accel;
  logic [7:0]  r_hold;
  logic        aw_hit, wr_go;
  logic [31:0] rd_val;
  logic [3:0]  sw_ctrl;
  logic        sw_ctrl_we;

  // true when byte is a letter usable as unit name
  function automatic logic is_letter(input logic [7:0] c);
    is_letter = (c >= 8'h41 && c <= 8'h5A) || (c >= 8'h61 && c <= 8'h7A); // [RQ23]
  endfunction : is_letter

  //////////////////////////////////////////////////////////////////////
  // pin and temperature synchronisers
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      in_s1 <= 4'hF;
      in_s2 <= 4'hF;
      t_s1  <= 8'h00;
      t_s2  <= 8'h00;
    end else begin
      in_s1 <= input_n_in;
      in_s2 <= in_s1;
      t_s1  <= temp_c_in;
      t_s2  <= t_s1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // motion generator
  ssc_motion u_motion (
    .sys_clk_in    (sys_clk_in),
    .resetn_in     (resetn_in),
    .mv            (mv.gen),
    .start_rate_in (r_start),
    .slew_rate_in  (r_slew),
    .accel_in      (r_accel),
    .hold_ticks_in (r_hold)
  );
  assign mv.start   = start;
  assign mv.dir_neg = dir;
  assign mv.count   = num[30:0];
  assign mv.kill    = kill;

  //////////////////////////////////////////////////////////////////////
  // character parser; addressed when single-axis or name prefix matched
  always_comb begin
    next_st   = st;
    next_op   = op;
    next_num  = num;
    next_pend = pend;
    next_tx   = tx;
    next_txv  = txv && !tx_ready_in;
    next_ctrl = sw_ctrl_we ? sw_ctrl : ctrl;
    next_dir  = dir;
    start     = 1'b0;
    kill      = 1'b0;
    if (rx_valid_in) begin
      if (rx_data_in == `SSC_CH_PIPE && (st == ssc_pkg::SSC_ADDR || !ctrl[`SSC_CTRL_MULTI])) begin
        // lone character, addressed unit only, no echo [RQ1] [RQ2] [RQ7] [RQ9]
        kill      = 1'b1;                                  // [RQ3]
        next_pend = 1'b0;
        next_ctrl[`SSC_CTRL_PROG]   = 1'b0;                // [RQ4]
        next_ctrl[`SSC_CTRL_RUNPRG] = 1'b0;                // [RQ4]
        next_ctrl[`SSC_CTRL_PENTRY] = 1'b0;                // nothing stored [RQ8]
        next_ctrl[`SSC_CTRL_MULTI]  = ctrl[`SSC_CTRL_MULTI]; // mode kept [RQ5]
        next_st   = ctrl[`SSC_CTRL_MULTI] ? ssc_pkg::SSC_IDLE : ssc_pkg::SSC_ADDR;
      end else begin
        case (st)
          ssc_pkg::SSC_IDLE: begin
            if (!ctrl[`SSC_CTRL_MULTI] || (is_letter(rx_data_in) && rx_data_in == name)) begin
              next_st = ssc_pkg::SSC_ADDR;
            end else if (rx_data_in != `SSC_CH_CR && rx_data_in != `SSC_CH_LF) begin
              next_st = ssc_pkg::SSC_LINE;                 // other unit: skip line
            end
          end
          ssc_pkg::SSC_ADDR: begin
            next_num = 32'h00000000;
            next_op  = ssc_pkg::SSC_OP_NONE;
            if (rx_data_in == `SSC_CH_CARET) begin
              next_txv = 1'b1;                             // answer at once [RQ12]
              if (ctrl[`SSC_CTRL_PROG]) begin
                next_tx = `SSC_CH_NAK;                     // invalid here [RQ11]
              end else begin
                next_tx = mv.moving ? `SSC_CH_ONE : `SSC_CH_ZERO; // [RQ10]
              end
            end else if (rx_data_in == `SSC_CH_BRACE) begin
              next_txv = 1'b1;
              next_tx  = t_s2;                             // degrees Celsius [RQ13]
            end else if (rx_data_in == `SSC_CH_PLUS) begin
              next_op = ssc_pkg::SSC_OP_PLUS;
              next_st = ssc_pkg::SSC_NUM;
            end else if (rx_data_in == `SSC_CH_MINUS) begin
              next_op = ssc_pkg::SSC_OP_MIN;               // [RQ21]
              next_st = ssc_pkg::SSC_NUM;
            end else if (rx_data_in == `SSC_CH_A_UP || rx_data_in == `SSC_CH_A_LO) begin
              next_op = ssc_pkg::SSC_OP_INP;
              next_st = ssc_pkg::SSC_NUM;
            end else if (rx_data_in != `SSC_CH_CR && rx_data_in != `SSC_CH_LF) begin
              next_st = ssc_pkg::SSC_LINE;                 // other command: skip line
            end
          end
          ssc_pkg::SSC_NUM: begin
            if (rx_data_in >= `SSC_CH_ZERO && rx_data_in <= 8'h39) begin
              next_num = 32'(num * 32'h0000000A) + {28'h0000000, rx_data_in[3:0]};
              if (next_num > `SSC_POS_MAX) begin
                next_num = `SSC_POS_MAX;                   // range limit [RQ14]
              end
            end else if (rx_data_in == `SSC_CH_CR || rx_data_in == `SSC_CH_LF) begin
              if (op == ssc_pkg::SSC_OP_INP) begin
                next_txv = 1'b1;
                next_tx  = {4'h0, ~in_s2};                 // low pin reads 1 [RQ22]
              end else begin
                next_pend = 1'b1;
                next_dir  = (op == ssc_pkg::SSC_OP_MIN);
              end
              next_st = ctrl[`SSC_CTRL_MULTI] ? ssc_pkg::SSC_IDLE : ssc_pkg::SSC_ADDR;
            end
          end
          default: begin
            if (rx_data_in == `SSC_CH_CR || rx_data_in == `SSC_CH_LF) begin
              next_st = ctrl[`SSC_CTRL_MULTI] ? ssc_pkg::SSC_IDLE : ssc_pkg::SSC_ADDR;
            end
          end
        endcase
      end
    end
    if (sw_ctrl_we && !kill && sw_ctrl[`SSC_CTRL_MULTI] != ctrl[`SSC_CTRL_MULTI]) begin
      next_st = sw_ctrl[`SSC_CTRL_MULTI] ? ssc_pkg::SSC_IDLE : ssc_pkg::SSC_ADDR;
    end
    // queued move leaves only after earlier motion has ended [RQ16] [RQ20]
    if (pend && !mv.moving && !kill) begin
      start     = 1'b1;
      next_pend = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // signed position counter, wraps both ways [RQ15] [RQ21]
  always_comb begin
    next_pos = pos;
    if (mv.step) begin
      next_pos = dir ? pos - 32'h00000001 : pos + 32'h00000001;
    end
  end

  // parser and position registers
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st   <= ssc_pkg::SSC_ADDR;
      op   <= ssc_pkg::SSC_OP_NONE;
      num  <= 32'h00000000;
      pend <= 1'b0;
      tx   <= 8'h00;
      txv  <= 1'b0;
      ctrl <= 4'h0;
      dir  <= 1'b0;
      pos  <= 32'h00000000;
    end else begin
      st   <= next_st;
      op   <= next_op;
      num  <= next_num;
      pend <= next_pend;
      tx   <= next_tx;
      txv  <= next_txv;
      ctrl <= next_ctrl;
      dir  <= next_dir;
      pos  <= next_pos;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // axi4-lite slave: write taken when address and data both present
  assign aw_hit  = awvalid && wvalid && !bvalid;
  assign awready = aw_hit;
  assign wready  = aw_hit;
  assign wr_go   = aw_hit;
  assign arready = !rvalid;
  assign bresp   = 2'b00;
  assign rresp   = 2'b00;
  assign sw_ctrl_we = wr_go && awaddr == `SSC_REG_CTRL && wstrb[0];
  assign sw_ctrl    = wdata[3:0];

  // readable view of block state
  always_comb begin
    if (araddr == `SSC_REG_CTRL) begin
      rd_val = {16'h0000, name, 4'h0, ctrl};
    end else if (araddr == `SSC_REG_PROF) begin
      rd_val = {16'h0000, r_accel};
    end else if (araddr == `SSC_REG_START) begin
      rd_val = {16'h0000, r_start};
    end else if (araddr == `SSC_REG_SLEW) begin
      rd_val = {16'h0000, r_slew};
    end else if (araddr == `SSC_REG_HOLD) begin
      rd_val = {24'h000000, r_hold};
    end else if (araddr == `SSC_REG_STATUS) begin
      rd_val = {24'h000000, pend, mv.run_cur, mv.moving, dir, ~in_s2};
    end else if (araddr == `SSC_REG_POS) begin
      rd_val = pos;
    end else if (araddr == `SSC_REG_TEMP) begin
      rd_val = {24'h000000, t_s2};
    end else begin
      rd_val = 32'h00000000;
    end
  end

  // bus registers and profile settings
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bvalid  <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      name    <= `SSC_RST_NAME;
      r_start <= `SSC_RST_START;
      r_slew  <= `SSC_RST_SLEW;
      r_accel <= `SSC_RST_ACCEL;
      r_hold  <= `SSC_RST_HOLD;
    end else begin
      bvalid <= wr_go || (bvalid && !bready);
      if (arvalid && !rvalid) begin
        rvalid <= 1'b1;
        rdata  <= rd_val;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
      if (wr_go && awaddr == `SSC_REG_CTRL && wstrb[1]) begin
        name <= wdata[15:8];
      end
      if (wr_go && awaddr == `SSC_REG_PROF) begin
        r_accel <= wdata[15:0];
      end
      if (wr_go && awaddr == `SSC_REG_START) begin
        r_start <= wdata[15:0];
      end
      if (wr_go && awaddr == `SSC_REG_SLEW) begin
        r_slew <= wdata[15:0];
      end
      if (wr_go && awaddr == `SSC_REG_HOLD) begin
        r_hold <= wdata[7:0];
      end
    end
  end

  // outputs; output-port logic is untouched by stop [RQ6]
  assign tx_valid_out    = txv;
  assign tx_data_out     = tx;
  assign step_out        = mv.step;
  assign dir_out         = dir;
  assign run_current_out = mv.run_cur;
  assign position_out    = pos;
endmodule : ssc_cmd

// ==== tb/ssc_cmd_properties.sv ====
// concurrent checks on the ports of the command block
`timescale 1ns/1ps
module ssc_cmd_properties (
  input wire logic        sys_clk_in,
  input wire logic        resetn_in,
  input wire logic        rx_valid_in,
  input wire logic [7:0]  rx_data_in,
  input wire logic        tx_valid_out,
  input wire logic [7:0]  tx_data_out,
  input wire logic        tx_ready_in,
  input wire logic        step_out,
  input wire logic        run_current_out,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);
  ////////////////////////////////////////////////////////////////////////////////
  // serial command side
  stop_no_step_a: assert property (rx_valid_in && rx_data_in == 8'h7C |=> !step_out [*3])
    else $error("step seen after hard stop");
  stop_no_echo_a: assert property (rx_valid_in && rx_data_in == 8'h7C |=> !$rose(tx_valid_out))
    else $error("reply raised for hard stop");
  status_reply_a: assert property (rx_valid_in && rx_data_in == 8'h5E |=>
    tx_valid_out && tx_data_out inside {8'h30, 8'h31, 8'h3F})
    else $error("status reply missing");
  step_run_a: assert property (step_out |-> run_current_out)
    else $error("step without run current");
  step_pulse_a: assert property (step_out |=> !step_out)
    else $error("step pulse too long");
  reply_hold_a: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out)
    else $error("reply dropped before taken");
  ////////////////////////////////////////////////////////////////////////////////
  // register bus side
  write_resp_a: assert property (awvalid && awready && wvalid && wready |=> bvalid && bresp == 2'b00)
    else $error("write response missing");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  read_resp_a: assert property (arvalid && arready |=> rvalid && rresp == 2'b00)
    else $error("read response missing");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  stop_seen_c: cover property (rx_valid_in && rx_data_in == 8'h7C);
  step_seen_c: cover property (step_out);
  read_seen_c: cover property (rvalid && rready);
endmodule : ssc_cmd_properties

bind ssc_cmd ssc_cmd_properties u_props (.*);

// ==== tb/ssc_host.sv ====
// host-side serial partner: sends bytes, takes replies promptly or slowly
`timescale 1ns/1ps
module ssc_host (
  input  wire logic       sys_clk_in,
  input  wire logic       slow_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  output logic            rx_valid_out,
  output logic [7:0]      rx_data_out,
  output logic            tx_ready_out
);
  logic [1:0] wait_cnt = 2'h0;
  logic [7:0] rep      = 8'h00;
  int         n_rep    = 0;
  initial rx_valid_out = 1'b0;
  initial rx_data_out = 8'h00;
  // slow mode stalls each reply for three cycles
  assign tx_ready_out = !slow_in || (wait_cnt == 2'h3);
  always @(posedge sys_clk_in) begin
    wait_cnt <= (tx_valid_in && !tx_ready_out) ? wait_cnt + 2'h1 : 2'h0;
    if (tx_valid_in && tx_ready_out) begin
      rep <= tx_data_in;
      n_rep <= n_rep + 1;
    end
  end
  task automatic send_byte(input logic [7:0] b);
    @(posedge sys_clk_in);
    rx_valid_out <= 1'b1;
    rx_data_out <= b;
    @(posedge sys_clk_in);
    rx_valid_out <= 1'b0;
    rx_data_out <= ~b; // idle line shows the inverse
  endtask : send_byte
  // axis prefix is always a letter
  task automatic send_name(input logic [7:0] c);
    send_byte((c inside {[8'h41:8'h5A], [8'h61:8'h7A]}) ? c : 8'h41);
  endtask : send_name
endmodule : ssc_host

// ==== tb/ssc_cmd_tb.sv ====
// self-checking bench for the stepper command block
`timescale 1ns/1ps
module ssc_cmd_tb;
  typedef struct {
    string      cmd;
    logic [3:0] inp_n;
    logic [7:0] temp;
    logic [7:0] exp_rep;
  } ssc_row_t;
  ssc_row_t    rows [6] = '{'{"^", 4'hF, 8'h00, 8'h30}, '{"{", 4'hF, 8'h19, 8'h19},
    '{"A\r", 4'hE, 8'h00, 8'h01}, '{"a\n", 4'h6, 8'h00, 8'h09},
    '{"A\n", 4'h0, 8'h00, 8'h0F}, '{"{", 4'hF, 8'h7F, 8'h7F}};
  logic [7:0]  reg_addr [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h40};
  logic [31:0] reg_rst [6] = '{32'h00004100, 32'h00000010, 32'h00000064,
    32'h000003E8, 32'h00000064, 32'h00000000};
  logic        sys_clk_in = 1'b0, resetn_in = 1'b0, slow = 1'b0;
  logic        rx_valid_in, tx_valid_out, tx_ready_in, step_out, dir_out, run_current_out;
  logic [7:0]  rx_data_in, tx_data_out;
  logic [7:0]  temp_c_in = 8'h00;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [3:0]  input_n_in = 4'hF, wstrb = 4'hF;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] position_out, rdata, rd, pos_exp;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  int          err_total = 0;
  int          tests_run = 0;
  int          steps = 0;
  int          n0, s;
  always #12.5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) if (step_out) steps <= steps + 1;
  ssc_cmd dut (.*);
  ssc_host host (.sys_clk_in, .slow_in(slow), .tx_valid_in(tx_valid_out),
    .tx_data_in(tx_data_out), .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in),
    .tx_ready_out(tx_ready_in));
  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] got);
    tests_run++;
    if (got !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, e, got);
    end
  endtask : check
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic cmd(input string str);
    foreach (str[i]) host.send_byte(str[i]);
  endtask : cmd
  task automatic ask(input string str, input logic [7:0] e, input string what);
    n0 = host.n_rep;
    cmd(str);
    while (host.n_rep == n0) @(posedge sys_clk_in);
    check(what, {24'h000000, e}, {24'h000000, host.rep});
  endtask : ask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    do @(posedge sys_clk_in); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge sys_clk_in); while (!bvalid);
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_in);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge sys_clk_in); while (!arready);
    arvalid <= 1'b0;
    do @(posedge sys_clk_in); while (!rvalid);
    d = rdata;
    rready <= 1'b0;
  endtask : axi_rd
  // moves n steps and checks count and final position
  task automatic move(input string str, input int n, input logic [31:0] p);
    s = steps;
    cmd(str);
    wait (steps == s + n);
    repeat (3000) @(posedge sys_clk_in);
    check("steps", n, steps - s);
    check("position", p, position_out);
  endtask : move
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (100000) @(posedge sys_clk_in);
    err_total++;
    $display("FAIL watchdog expected finish seen hang");
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    foreach (rows[i]) begin
      @(posedge sys_clk_in);
      input_n_in <= rows[i].inp_n;
      temp_c_in <= rows[i].temp;
      slow <= i[0];
      repeat (4) @(posedge sys_clk_in);
      ask(rows[i].cmd, rows[i].exp_rep, "reply");
    end
    // equal start and slew: no ramp
    axi_wr(8'h08, 32'h0000FFFF);
    axi_wr(8'h0C, 32'h0000FFFF);
    s = steps;
    cmd("+5\r");
    ask("^", 8'h31, "busy status");
    wait (steps == s + 5);
    repeat (3000) @(posedge sys_clk_in);
    check("steps", 5, steps - s);
    ask("^", 8'h30, "idle status");
    move("-3\r", 3, 32'h00000002);
    check("direction", 32'h00000001, {31'h0, dir_out});
    move("+0\r", 0, 32'h00000002);
    axi_wr(8'h08, 32'h00004000);
    move("+8\r", 8, 32'h0000000A);
    // hard stop mid-move, single axis
    axi_wr(8'h08, 32'h0000FFFF);
    s = steps;
    cmd("+99\r");
    wait (steps == s + 4);
    n0 = host.n_rep;
    cmd("|");
    pos_exp = 32'h0000000A + 32'(steps - s);
    repeat (2000) @(posedge sys_clk_in);
    check("stop position", pos_exp, position_out);
    check("echo count", n0, host.n_rep);
    // program mode query refused, then stop leaves program entry
    axi_wr(8'h00, 32'h00004102);
    ask("^", 8'h3F, "program status");
    axi_wr(8'h00, 32'h0000410E);
    cmd("|");
    axi_rd(8'h00, rd);
    check("control", 32'h00004100, rd);
    // multi-axis addressed stop
    axi_wr(8'h00, 32'h00004101);
    s = steps;
    host.send_name(8'h41);
    cmd("+99\r");
    wait (steps == s + 3);
    host.send_name(8'h41);
    cmd("|");
    pos_exp = position_out;
    repeat (2000) @(posedge sys_clk_in);
    check("multi stop", pos_exp, position_out);
    axi_rd(8'h00, rd);
    check("control", 32'h00004101, rd);
    // second reset, then reset values and an unmapped place
    resetn_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    check("reset position", 32'h00000000, position_out);
    resetn_in <= 1'b1;
    foreach (reg_addr[i]) begin
      axi_rd(reg_addr[i], rd);
      check("register", reg_rst[i], rd);
    end
    wrap_up();
  end
endmodule : ssc_cmd_tb
